/* File: fis_mem_if.sv */
// Carrier between the indicator core and its setting memory
`timescale 1ns/1ps
`default_nettype none
interface fis_mem_if;
  logic wr_en;
  logic [3:0] waddr;
  logic [15:0] wdata;
  logic rd_en;
  logic [3:0] raddr;
  logic bypass_sel;
  logic [15:0] bypass_data;
  logic [15:0] bus_rdata;
  logic [3:0] disp_raddr;
  logic [15:0] disp_rdata;

  modport ctrl (output wr_en, waddr, wdata, rd_en, raddr, bypass_sel, bypass_data, disp_raddr,
                input bus_rdata, disp_rdata);
  modport mem (input wr_en, waddr, wdata, rd_en, raddr, bypass_sel, bypass_data, disp_raddr,
               output bus_rdata, disp_rdata);
endinterface : fis_mem_if
`default_nettype wire

/* File: fis_panel_model.sv */
// Model of the reset sources outside the indicator: push-buttons and control input
`timescale 1ns/1ps
`default_nettype none
module fis_panel_model (
  input wire logic clk_i,
  input wire logic [1:0] req_i,
  output logic pb_reset_o,
  output logic ext_reset_o
);
  // ---------------------------------------------------------------------
  // Reset requests
  // ---------------------------------------------------------------------
  // One register stage, as a debounced button or input would give
  always_ff @(posedge clk_i) begin
    pb_reset_o <= req_i[0];
    ext_reset_o <= req_i[1];
  end
endmodule : fis_panel_model
`default_nettype wire

/* File: fis_pkg.sv */
// Shared constants, register map and setting limits of the fault indicator block
package fis_pkg;

  // ---------------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TRIP_CFG = 5'h01;
  localparam logic [4:0] ADDR_STATUS = 5'h02;
  localparam logic [4:0] ADDR_PARAM = 5'h03;
  localparam logic [4:0] ADDR_RESET = 5'h04;
  localparam logic [4:0] ADDR_RATED = 5'h05;
  localparam logic [4:0] ADDR_SET_BASE = 5'h10;

  // ---------------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------------
  localparam int CTRL_W = 7;
  localparam int CTL_HIGH_OFF = 0;   // stage_function_group: high stage out of use
  localparam int CTL_VOLT_MODE = 1;  // stage_function_group: stages 1 and 2 measure voltage
  localparam int CTL_AUTORESET = 2;  // voltage_trip_autoreset_switch
  localparam int CTL_LATCH_CUR = 3;  // start_latch_switches, current stages
  localparam int CTL_LATCH_VOLT = 4; // start_latch_switches, voltage stages
  localparam int CTL_RATED_LSB = 5;  // rated_voltage_select, two bits
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int TRIP_CFG_W = 4;     // bits 0..2 stage operates, bit 3 breaker failure
  localparam logic [3:0] TRIP_CFG_RESET = 4'hF;
  localparam logic [1:0] RATED_ILLEGAL = 2'h3;

  // Rated residual voltage in volts per select code
  localparam logic [7:0] RATED_100 = 8'h64;
  localparam logic [7:0] RATED_110 = 8'h6E;
  localparam logic [7:0] RATED_120 = 8'h78;

  // ---------------------------------------------------------------------
  // Indication codes (display code equals status value except breaker failure)
  // ---------------------------------------------------------------------
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_RV_START = 4'h1;
  localparam logic [3:0] CODE_RV_OPER = 4'h2;
  localparam logic [3:0] CODE_LOW_START = 4'h3;
  localparam logic [3:0] CODE_LOW_OPER = 4'h4;
  localparam logic [3:0] CODE_HIGH_START = 4'h5;
  localparam logic [3:0] CODE_HIGH_OPER = 4'h6;
  localparam logic [3:0] CODE_BFP_DISP = 4'hA;
  localparam logic [7:0] PARAM_BFP = 8'h0C;
  localparam logic [3:0] FAULT_LEAD = 4'h1;

  // ---------------------------------------------------------------------
  // Settings: index, units of 0.1 % or 0.1 s, limits and defaults
  // ---------------------------------------------------------------------
  localparam int NUM_SET = 9;
  localparam logic [3:0] SET_RV_THR = 4'h0;
  localparam logic [3:0] SET_RV_TIME = 4'h1;
  localparam logic [3:0] SET_LOW_CUR = 4'h2;
  localparam logic [3:0] SET_LOW_VOLT = 4'h3;
  localparam logic [3:0] SET_LOW_TIME = 4'h4;
  localparam logic [3:0] SET_HIGH_CUR = 4'h5;
  localparam logic [3:0] SET_HIGH_VOLT = 4'h6;
  localparam logic [3:0] SET_HIGH_TIME = 4'h7;
  localparam logic [3:0] SET_BFP_TIME = 4'h8;
  localparam logic [15:0] CUR_MIN = 16'h000A;   // 1.0 %
  localparam logic [15:0] CUR_MAX = 16'h03E8;   // 100 %
  localparam logic [15:0] VOLT_MIN = 16'h0014;  // 2.0 %
  localparam logic [15:0] VOLT_MAX = 16'h0320;  // 80.0 %
  localparam logic [15:0] TIME_MIN = 16'h0001;  // 0.1 s
  localparam logic [15:0] TIME_MAX = 16'h0BB8;  // 300 s
  localparam logic [15:0] BFP_MIN = 16'h0001;   // 0.1 s
  localparam logic [15:0] BFP_MAX = 16'h000A;   // 1.0 s
  localparam logic [15:0] BFP_DEF = 16'h0002;   // 0.2 s

  // Lower limit of a setting; the lower limit is also the default except breaker failure
  function automatic logic [15:0] set_min(input logic [3:0] idx);
    unique case (idx)
      SET_LOW_CUR, SET_HIGH_CUR: set_min = CUR_MIN;
      SET_RV_THR, SET_LOW_VOLT, SET_HIGH_VOLT: set_min = VOLT_MIN;
      SET_BFP_TIME: set_min = BFP_MIN;
      default: set_min = TIME_MIN;
    endcase
  endfunction : set_min

  function automatic logic [15:0] set_max(input logic [3:0] idx);
    unique case (idx)
      SET_LOW_CUR, SET_HIGH_CUR: set_max = CUR_MAX;
      SET_RV_THR, SET_LOW_VOLT, SET_HIGH_VOLT: set_max = VOLT_MAX;
      SET_BFP_TIME: set_max = BFP_MAX;
      default: set_max = TIME_MAX;
    endcase
  endfunction : set_max

  function automatic logic [15:0] set_default(input logic [3:0] idx);
    set_default = (idx == SET_BFP_TIME) ? BFP_DEF : set_min(idx);
  endfunction : set_default

  // Out-of-range writes are pulled to the nearest limit
  function automatic logic [15:0] set_clamp(input logic [3:0] idx, input logic [15:0] val);
    if (val < set_min(idx)) begin
      set_clamp = set_min(idx);
    end else if (val > set_max(idx)) begin
      set_clamp = set_max(idx);
    end else begin
      set_clamp = val;
    end
  endfunction : set_clamp

endpackage : fis_pkg

/* File: fis_set_mem.sv */
// Setting memory with a bus read port and a display read port, both registered
`timescale 1ns/1ps
`default_nettype none
module fis_set_mem
  import fis_pkg::*;
#(
  parameter int NUM = NUM_SET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  fis_mem_if.mem mif
);

  // Four address bits reach at most sixteen settings
  if (NUM < 1 || NUM > 16) begin : g_bad_num
    $error("fis_set_mem: NUM must be 1 to 16");
  end

  typedef struct packed {
    logic [NUM-1:0][15:0] mem;
    logic [15:0] bus_rdata;
    logic [15:0] disp_rdata;
  } fis_mem_state_t;

  // Reset image: every setting at its default
  function automatic fis_mem_state_t reset_image();
    reset_image = '0;
    for (int i = 0; i < NUM; i++) begin
      reset_image.mem[i] = set_default(4'(i));
    end
  endfunction : reset_image

  localparam fis_mem_state_t RST = reset_image();

  fis_mem_state_t r;
  fis_mem_state_t next_r;

  // ---------------------------------------------------------------------
  // Next state: clamped writes, bus read only in the cycle after the strobe
  // ---------------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (mif.wr_en && (32'(mif.waddr) < NUM)) begin
      next_r.mem[mif.waddr] = set_clamp(mif.waddr, mif.wdata);
    end
    next_r.bus_rdata = 16'h0000;
    if (mif.rd_en) begin
      if (mif.bypass_sel) begin
        next_r.bus_rdata = mif.bypass_data;
      end else if (32'(mif.raddr) < NUM) begin
        next_r.bus_rdata = r.mem[mif.raddr];
      end
    end
    next_r.disp_rdata = (32'(mif.disp_raddr) < NUM) ? r.mem[mif.disp_raddr] : 16'h0000;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign mif.bus_rdata = r.bus_rdata;
  assign mif.disp_rdata = r.disp_rdata;

endmodule : fis_set_mem
`default_nettype wire

/* File: fis_top.sv */
// Fault indicator and setting logic of the directional earth-fault module
`timescale 1ns/1ps
`default_nettype none
module fis_top
  import fis_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [4:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [2:0] stage_start_i,
  input wire logic [2:0] stage_oper_i,
  input wire logic bfp_oper_i,
  input wire logic pb_reset_i,
  input wire logic ext_reset_i,
  input wire logic ss_fault_i,
  input wire logic [3:0] ss_code_i,
  input wire logic [3:0] disp_sel_i,
  output logic [3:0] disp_code_o,
  output logic [7:0] ind_param_o,
  output logic trip_lamp_o,
  output logic ss_alarm_lamp_o,
  output logic ss_relay_o,
  output logic [7:0] ss_fault_code_o,
  output logic [15:0] set_value_o,
  output logic set_dash_o,
  output logic [NUM_SET-1:0] set_led_o,
  output logic [7:0] rated_voltage_o,
  output logic [2:0] start_ind_o,
  output logic [2:0] oper_ind_o,
  output logic bfp_ind_o
);

  // ---------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------
  if (DATA_W != 16) begin : g_bad_width
    $error("fis_top: DATA_W must be 16");
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [TRIP_CFG_W-1:0] trip_cfg;
    logic [2:0] start_ind;
    logic [2:0] oper_ind;
    logic bfp_ind;
    logic trip_lamp;
    logic ss_fault;
    logic [7:0] ss_fault_code;
    logic [3:0] disp_code;
    logic [7:0] ind_param;
    logic [3:0] sel_d;
    logic dash_d;
    logic [15:0] set_value;
    logic set_dash;
    logic [NUM_SET-1:0] set_led;
    logic [7:0] rated;
  } fis_state_t;

  localparam fis_state_t RST = '{ctrl: CTRL_RESET, trip_cfg: TRIP_CFG_RESET, rated: RATED_100, default: '0};

  fis_state_t r;
  fis_state_t next_r;
  fis_mem_if mif ();

  // Rated voltage for a select code; the illegal code never gets stored
  function automatic logic [7:0] rated_of(input logic [1:0] code);
    unique case (code)
      2'h1: rated_of = RATED_110;
      2'h2: rated_of = RATED_120;
      default: rated_of = RATED_100;
    endcase
  endfunction : rated_of

  // Dashes for a setting that belongs to a stage out of use or a measuring mode not in use
  function automatic logic dash_of(input logic [3:0] idx, input logic [CTRL_W-1:0] ctl);
    logic high_off;
    logic volt;
    high_off = ctl[CTL_HIGH_OFF];
    volt = ctl[CTL_VOLT_MODE];
    unique case (idx)
      SET_LOW_CUR: dash_of = volt;
      SET_LOW_VOLT: dash_of = !volt;
      SET_HIGH_CUR: dash_of = high_off || volt;
      SET_HIGH_VOLT: dash_of = high_off || !volt;
      SET_HIGH_TIME: dash_of = high_off;
      default: dash_of = 1'b0;
    endcase
  endfunction : dash_of

  // ---------------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------------
  logic ser_reset;
  logic rst_req;
  logic set_hit;
  logic [2:0] latch_en;
  logic [2:0] oper_ev;
  logic auto_clear;

  assign ser_reset = wr_i && (addr_i == ADDR_RESET) && wdata_i[0];
  assign rst_req = pb_reset_i || ext_reset_i || ser_reset;
  assign set_hit = (addr_i >= ADDR_SET_BASE) && (addr_i < (ADDR_SET_BASE + 5'(NUM_SET)));

  // Residual stage is always a voltage stage; the others follow the measuring mode
  assign latch_en[0] = r.ctrl[CTL_LATCH_VOLT];
  assign latch_en[1] = r.ctrl[CTL_VOLT_MODE] ? r.ctrl[CTL_LATCH_VOLT] : r.ctrl[CTL_LATCH_CUR];
  assign latch_en[2] = latch_en[1];
  assign oper_ev = stage_oper_i;
  assign auto_clear = r.ctrl[CTL_AUTORESET] && !stage_start_i[0] && !stage_oper_i[0];

  // ---------------------------------------------------------------------
  // Memory port drive
  // ---------------------------------------------------------------------
  always_comb begin
    mif.wr_en = wr_i && set_hit;
    mif.waddr = 4'(addr_i - ADDR_SET_BASE);
    mif.wdata = wdata_i;
    mif.rd_en = rd_i;
    mif.raddr = 4'(addr_i - ADDR_SET_BASE);
    mif.bypass_sel = !set_hit;
    mif.disp_raddr = disp_sel_i;
    unique case (addr_i)
      ADDR_CTRL: mif.bypass_data = 16'(r.ctrl);
      ADDR_TRIP_CFG: mif.bypass_data = 16'(r.trip_cfg);
      ADDR_STATUS: mif.bypass_data = {5'h00, r.ss_fault, r.trip_lamp, r.bfp_ind, 2'h0, r.oper_ind, r.start_ind};
      ADDR_PARAM: mif.bypass_data = {8'h00, r.ind_param};
      ADDR_RATED: mif.bypass_data = {8'h00, r.rated};
      default: mif.bypass_data = 16'h0000; // Unmapped and write-only addresses read zero
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_r = r;

    // Software switches; the illegal rated code leaves the field unchanged
    if (wr_i && (addr_i == ADDR_CTRL)) begin
      next_r.ctrl = wdata_i[CTRL_W-1:0];
      if (wdata_i[CTL_RATED_LSB +: 2] == RATED_ILLEGAL) begin
        next_r.ctrl[CTL_RATED_LSB +: 2] = r.ctrl[CTL_RATED_LSB +: 2];
      end
    end
    if (wr_i && (addr_i == ADDR_TRIP_CFG)) begin
      next_r.trip_cfg = wdata_i[TRIP_CFG_W-1:0];
    end
    next_r.rated = rated_of(r.ctrl[CTL_RATED_LSB +: 2]);

    // Indications: live event sets, reset request clears, and set wins over clear
    for (int s = 0; s < 3; s++) begin
      next_r.oper_ind[s] = oper_ev[s] || (r.oper_ind[s] && !rst_req);
      next_r.start_ind[s] = stage_start_i[s] || (latch_en[s] && r.start_ind[s] && !rst_req);
      if (next_r.oper_ind[s]) begin
        next_r.start_ind[s] = 1'b0;
      end
    end
    if (auto_clear) begin
      next_r.oper_ind[0] = 1'b0;
    end
    next_r.bfp_ind = bfp_oper_i || (r.bfp_ind && !rst_req);

    // Shared trip lamp, fed only by the events the config group selects
    next_r.trip_lamp = (|(oper_ev & r.trip_cfg[2:0])) || (bfp_oper_i && r.trip_cfg[3])
                       || (r.trip_lamp && !rst_req);

    // Self-supervision: sticky until power-on reset, immune to display resets
    if (ss_fault_i && !r.ss_fault) begin
      next_r.ss_fault = 1'b1;
      next_r.ss_fault_code = {FAULT_LEAD, ss_code_i};
    end

    // Display code priority: breaker failure, then operates, then starts
    next_r.disp_code = CODE_NONE;
    next_r.ind_param = 8'h00;
    if (r.bfp_ind) begin
      next_r.disp_code = CODE_BFP_DISP;
      next_r.ind_param = PARAM_BFP;
    end else if (r.oper_ind[2]) begin
      next_r.disp_code = CODE_HIGH_OPER;
    end else if (r.oper_ind[1]) begin
      next_r.disp_code = CODE_LOW_OPER;
    end else if (r.oper_ind[0]) begin
      next_r.disp_code = CODE_RV_OPER;
    end else if (r.start_ind[2]) begin
      next_r.disp_code = CODE_HIGH_START;
    end else if (r.start_ind[1]) begin
      next_r.disp_code = CODE_LOW_START;
    end else if (r.start_ind[0]) begin
      next_r.disp_code = CODE_RV_START;
    end
    if (!r.bfp_ind) begin
      next_r.ind_param = {4'h0, next_r.disp_code};
    end

    // Setting display pipeline, aligned with the memory read register
    next_r.sel_d = disp_sel_i;
    next_r.dash_d = dash_of(disp_sel_i, r.ctrl);
    next_r.set_value = mif.disp_rdata;
    next_r.set_dash = r.dash_d;
    next_r.set_led = '0;
    if (32'(r.sel_d) < NUM_SET) begin
      next_r.set_led[r.sel_d] = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------
  // Setting memory
  // ---------------------------------------------------------------------
  fis_set_mem #(
    .NUM(NUM_SET)
  ) u_set_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mif(mif.mem)
  );

  // ---------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------------
  // Indications only leave the block; nothing here feeds the measuring stages
  assign rdata_o = mif.bus_rdata;
  assign disp_code_o = r.disp_code;
  assign ind_param_o = r.ind_param;
  assign trip_lamp_o = r.trip_lamp;
  assign ss_alarm_lamp_o = r.ss_fault;
  assign ss_relay_o = r.ss_fault;
  assign ss_fault_code_o = r.ss_fault_code;
  assign set_value_o = r.set_value;
  assign set_dash_o = r.set_dash;
  assign set_led_o = r.set_led;
  assign rated_voltage_o = r.rated;
  assign start_ind_o = r.start_ind;
  assign oper_ind_o = r.oper_ind;
  assign bfp_ind_o = r.bfp_ind;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  chk_oper_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && stage_oper_i[1]) ##1 (ce_i && !rst_req)[*2] |=> oper_ind_o[1])
    else $error("operate indication lost without reset");

  chk_start_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !stage_start_i[2] && !stage_oper_i[2] && !latch_en[2] && !wr_i) |=> !start_ind_o[2])
    else $error("unlatched start indication stayed on");

  chk_start_replaced: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && stage_start_i[0] && stage_oper_i[0]) |=> (oper_ind_o[0] && !start_ind_o[0]))
    else $error("start code not replaced by operate code");

  chk_bfp_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && bfp_oper_i) ##1 (ce_i && !rst_req) |=> (disp_code_o == CODE_BFP_DISP && ind_param_o == PARAM_BFP))
    else $error("breaker failure code wrong");

  chk_alarm_relay: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ss_fault_i) |=> (ss_alarm_lamp_o && ss_relay_o && ss_fault_code_o[7:4] == FAULT_LEAD))
    else $error("self-supervision outputs not raised together");

  chk_fault_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ss_alarm_lamp_o && rst_req) |=> $stable(ss_fault_code_o) && ss_alarm_lamp_o)
    else $error("fault code cleared by display reset");

  chk_trip_lamp_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && stage_oper_i[1] && r.trip_cfg[1]) |=> trip_lamp_o)
    else $error("selected operate did not light trip lamp");

  chk_auto_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && auto_clear) |=> !oper_ind_o[0])
    else $error("auto-reset did not clear residual trip indication");

  chk_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rst_req && !stage_oper_i[2]) |=> !oper_ind_o[2])
    else $error("reset request did not clear indication");

  chk_reset_while_oper: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rst_req && stage_oper_i[2]) |=> oper_ind_o[2])
    else $error("operating stage lost indication on reset");

  chk_dash_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !wr_i && disp_sel_i == SET_HIGH_TIME && r.ctrl[CTL_HIGH_OFF]) ##1 ce_i |=> set_dash_o)
    else $error("disabled stage setting not dashed");

  chk_code_table: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !r.bfp_ind && r.oper_ind == 3'h0 && r.start_ind == 3'h1) |=> (disp_code_o == CODE_RV_START && ind_param_o == 8'h01))
    else $error("residual start code wrong");

  chk_led_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && disp_sel_i == SET_BFP_TIME) ##1 ce_i |=> ($onehot(set_led_o) && set_led_o[SET_BFP_TIME]))
    else $error("setting lamp does not mark shown setting");

  chk_rated_select: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_i && addr_i == ADDR_CTRL && wdata_i[CTL_RATED_LSB +: 2] == 2'h2) ##1 ce_i
    |=> rated_voltage_o == RATED_120)
    else $error("rated voltage select not applied");

endmodule : fis_top
`default_nettype wire

/* File: fis_top_tb_top.sv */
// Self-checking testbench of the fault indicator block
`timescale 1ns/1ps
`default_nettype none
module fis_top_tb_top;
  import fis_pkg::*;
  typedef struct packed {logic [2:0] st; logic [2:0] op; logic bf; logic [3:0] dc; logic [7:0] pv;} fis_row_t;
  // ---------------------------------------------------------------------
  // Ordinary cases: stage inputs beside the codes they give
  // ---------------------------------------------------------------------
  localparam fis_row_t ROWS [7] = '{'{3'h1, 3'h0, 1'b0, 4'h1, 8'h01}, '{3'h0, 3'h1, 1'b0, 4'h2, 8'h02},
    '{3'h2, 3'h0, 1'b0, 4'h3, 8'h03}, '{3'h0, 3'h2, 1'b0, 4'h4, 8'h04}, '{3'h4, 3'h0, 1'b0, 4'h5, 8'h05},
    '{3'h0, 3'h4, 1'b0, 4'h6, 8'h06}, '{3'h0, 3'h0, 1'b1, 4'hA, 8'h0C}};
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, bf = 0, ssf = 0, pb, ext;
  logic [4:0] addr = 0;
  logic [15:0] wd = 0, rdata;
  logic [2:0] st = 0, op = 0, si, oi;
  logic [1:0] req = 0;
  logic [3:0] ssc = 0, dc;
  logic [7:0] pv, rv, sfc;
  logic [3:0] sel = 0;
  logic [15:0] sv;
  logic [NUM_SET-1:0] led;
  logic lamp, ssl, ssr, sd, bfi;
  int n_mismatch = 0, check_count = 0;
  // Clock at 20 MHz
  always #25 clk_i = ~clk_i;
  fis_top u_fis_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr), .wdata_i(wd), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .stage_start_i(st), .stage_oper_i(op), .bfp_oper_i(bf), .pb_reset_i(pb),
    .ext_reset_i(ext), .ss_fault_i(ssf), .ss_code_i(ssc), .disp_sel_i(sel), .disp_code_o(dc),
    .ind_param_o(pv), .trip_lamp_o(lamp), .ss_alarm_lamp_o(ssl), .ss_relay_o(ssr), .ss_fault_code_o(sfc),
    .set_value_o(sv), .set_dash_o(sd), .set_led_o(led), .rated_voltage_o(rv), .start_ind_o(si),
    .oper_ind_o(oi), .bfp_ind_o(bfi));
  fis_panel_model u_fis_panel_model (.clk_i(clk_i), .req_i(req), .pb_reset_o(pb), .ext_reset_o(ext));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : settle
  // Stage levels held until the next call
  task automatic stage(input logic [2:0] s, input logic [2:0] o, input logic b);
    @(posedge clk_i);
    st <= s;
    op <= o;
    bf <= b;
    settle();
  endtask : stage
  // One-cycle request to the reset model: 1 buttons, 2 control input
  task automatic clr(input logic [1:0] k);
    @(posedge clk_i);
    req <= k;
    @(posedge clk_i);
    req <= 2'h0;
    settle();
  endtask : clr
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    settle();
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #100_000;
    n_mismatch++;
    give_verdict();
  end
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    cmp(16'(rv), 16'(RATED_100));
    cmp(16'(lamp), 16'h0000);
    rd(ADDR_SET_BASE, VOLT_MIN);
    rd(ADDR_SET_BASE + 5'h02, CUR_MIN);
    rd(ADDR_SET_BASE + 5'h07, TIME_MIN);
    rd(ADDR_SET_BASE + 5'h08, BFP_DEF);
    $display("test reset values done");
    foreach (ROWS[i]) begin
      stage(ROWS[i].st, ROWS[i].op, ROWS[i].bf);
      cmp(16'(dc), 16'(ROWS[i].dc));
      cmp(16'(pv), 16'(ROWS[i].pv));
      cmp(16'(lamp), 16'(|ROWS[i].op | ROWS[i].bf));
      cmp(16'(bfi), 16'(ROWS[i].bf));
      stage(3'h0, 3'h0, 1'b0);
      clr(2'h1);
      cmp(16'(dc), 16'(CODE_NONE));
    end
    $display("test code table done");
    // Start turns into operate, then latches after dropout
    stage(3'h2, 3'h0, 1'b0);
    cmp(16'(dc), 16'(CODE_LOW_START));
    stage(3'h2, 3'h2, 1'b0);
    cmp(16'(dc), 16'(CODE_LOW_OPER));
    stage(3'h0, 3'h0, 1'b0);
    cmp(16'(dc), 16'(CODE_LOW_OPER));
    cmp(16'(lamp), 16'h0001);
    clr(2'h2);
    cmp(16'(lamp), 16'h0000);
    // Reset while still operating sets again; serial reset clears later
    stage(3'h0, 3'h4, 1'b0);
    clr(2'h1);
    cmp(16'(oi), 16'h0004);
    stage(3'h0, 3'h0, 1'b0);
    wr(ADDR_RESET, 16'h0001);
    cmp(16'(lamp), 16'h0000);
    $display("test latch and reset done");
    // Auto-reset drops the residual operate flag, the lamp stays lit
    wr(ADDR_CTRL, 16'h0004);
    stage(3'h0, 3'h1, 1'b0);
    cmp(16'(oi), 16'h0001);
    stage(3'h0, 3'h0, 1'b0);
    cmp(16'(oi), 16'h0000);
    cmp(16'(lamp), 16'h0001);
    clr(2'h1);
    $display("test auto-reset done");
    // Latched start of a current stage, then a new event proceeds
    wr(ADDR_CTRL, 16'h0008);
    stage(3'h2, 3'h0, 1'b0);
    stage(3'h0, 3'h0, 1'b0);
    cmp(16'(si), 16'h0002);
    stage(3'h1, 3'h0, 1'b0);
    cmp(16'(si), 16'h0003);
    stage(3'h0, 3'h0, 1'b0);
    clr(2'h1);
    cmp(16'(si), 16'h0000);
    // Voltage mode: the low stage latches with the voltage switch
    wr(ADDR_CTRL, 16'h0012);
    stage(3'h2, 3'h0, 1'b0);
    stage(3'h0, 3'h0, 1'b0);
    cmp(16'(si), 16'h0002);
    clr(2'h2);
    wr(ADDR_SET_BASE, 16'h0384);
    rd(ADDR_SET_BASE, VOLT_MAX);
    wr(ADDR_CTRL, 16'h0040);
    cmp(16'(rv), 16'(RATED_120));
    // Illegal rated code keeps the old one; high stage goes out of use
    wr(ADDR_CTRL, 16'h0061);
    cmp(16'(rv), 16'(RATED_120));
    wr(ADDR_SET_BASE + 5'h01, 16'h0BB8);
    rd(ADDR_SET_BASE + 5'h01, TIME_MAX);
    @(posedge clk_i);
    sel <= SET_BFP_TIME;
    settle();
    cmp(sv, BFP_DEF);
    cmp(16'(led), 16'h0100);
    cmp(16'(sd), 16'h0000);
    @(posedge clk_i);
    sel <= SET_HIGH_TIME;
    settle();
    cmp(16'(sd), 16'h0001);
    $display("test settings done");
    // Internal fault ignores a push-button reset request
    @(posedge clk_i);
    ssc <= 4'h5;
    ssf <= 1'b1;
    settle();
    cmp({14'h0000, ssl, ssr}, 16'h0003);
    cmp(16'(sfc), 16'({FAULT_LEAD, 4'h5}));
    clr(2'h1);
    cmp(16'(ssl), 16'h0001);
    $display("test self-supervision done");
    // Reset in mid-run clears the alarm and restores defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    ssf <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    cmp(16'(ssl), 16'h0000);
    cmp(16'(rv), 16'(RATED_100));
    rd(ADDR_SET_BASE + 5'h01, TIME_MIN);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : fis_top_tb_top
`default_nettype wire
